// *** core/vrmfs_pkg.sv ***
// constants and types of the supervisor
package vrmfs_pkg;
  // ********************
  // clock and timing
  // ********************
  localparam int CLK_PERIOD_NS      = 4;
  localparam int VCODE_STEP_UV      = 5000;
  localparam int FAST_RATE_UV_US    = 10000;
  localparam int SLOW_RATE_UV_US    = 2500;
  localparam int FAST_STEP_NS       = VCODE_STEP_UV * 1000 / FAST_RATE_UV_US;
  localparam int SLOW_STEP_NS       = VCODE_STEP_UV * 1000 / SLOW_RATE_UV_US;
  // a minimum slew rate gives a longest step time, so round down
  localparam int FAST_STEP_CYC      = FAST_STEP_NS / CLK_PERIOD_NS;
  localparam int SLOW_STEP_CYC      = SLOW_STEP_NS / CLK_PERIOD_NS;
  localparam int OC_WINDOW_US       = 120;
  localparam int IMB_WINDOW_MS      = 1;
  // least times round up
  localparam int OC_WINDOW_CYC      = (OC_WINDOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IMB_WINDOW_CYC     = (IMB_WINDOW_MS * 1000000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int ZC_CYCLES_FOR_DCM  = 4;
  localparam int STEP_CNT_W         = 10;
  localparam int WIN_CNT_W          = 20;
  localparam int CFG_WAIT           = 3;
  // ********************
  // voltage codes and commands
  // ********************
  localparam int VCODE_W            = 8;
  localparam logic [VCODE_W-1:0] VCODE_ZERO = 8'h00;
  localparam logic [VCODE_W-1:0] BOOT_CODE  = 8'h00;
  typedef enum logic [2:0] {
    CMD_NONE        = 3'h0,
    CMD_STEP_FAST   = 3'h1,
    CMD_STEP_SLOW   = 3'h2,
    CMD_STEP_DECAY  = 3'h3,
    CMD_SET_PSTATE  = 3'h4,
    CMD_READ_STATUS = 3'h5
  } vrmfs_cmd_type;
  typedef struct packed {
    vrmfs_cmd_type          code;
    logic [VCODE_W-1:0]     data;
  } vrmfs_link_cmd_type;
  typedef enum logic [1:0] {
    FULL_POWER_STATE    = 2'h0,
    REDUCED_POWER_STATE = 2'h1,
    LIGHT_POWER_STATE   = 2'h2,
    LOWEST_POWER_STATE  = 2'h3
  } vrmfs_pstate_type;
  typedef enum logic [1:0] {
    CFG_THREE = 2'h0,
    CFG_TWO   = 2'h1,
    CFG_ONE   = 2'h2
  } vrmfs_cfg_type;
  typedef enum logic [1:0] {
    SPACING_120 = 2'h0,
    SPACING_180 = 2'h1,
    SPACING_NONE = 2'h2
  } vrmfs_spacing_type;
  localparam logic [2:0] MASK_THREE = 3'h7;
  localparam logic [2:0] MASK_TWO   = 3'h3;
  localparam logic [2:0] MASK_ONE   = 3'h1;
  // ********************
  // analog comparator results
  // ********************
  typedef struct packed {
    logic oc_above;
    logic way_oc;
    logic imbalance;
    logic ov_code;
    logic ov_fixed;
    logic ntc_below_091;
    logic ntc_above_095;
    logic ntc_below_093;
    logic ntc_above_097;
    logic zero_cross;
    logic cycle_tick;
    logic vout_below_ref;
  } vrmfs_cmp_type;
  typedef struct packed {
    logic overcurrent;
    logic way_overcurrent;
    logic imbalance;
    logic overvoltage;
  } vrmfs_fault_type;
  localparam vrmfs_fault_type FAULT_NONE = 4'h0;
endpackage : vrmfs_pkg

// *** core/vrmfs_supervisor.sv ***
// mode, slew and fault supervisor of a multiphase buck controller
// Functional notes
// - third phase drive strapped high: two phases, pulses 180 degrees apart
// - third drive and phase2 sense strapped high: one phase, no balancing
// - three-phase: full 3 CCM, reduced 2 or 1 CCM, light/lowest 1 DE
// - two/one-phase tables; reduced-state phase count follows config strap two only in three-phase
// - power state comes from set command or from the power state pin
// - fast step: CCM, reference slews at least 10mV per us
// - slow step: CCM, reference slews at least 2.5mV per us
// - decay step: diode emulation, fall follows load, clamped to slow rate
// - alert low after fast or slow step completes, never after decay
// - in diode emulation a raised code drives up, then emulation resumes
// - discontinuous mode only after four consecutive zero crossing cycles
// - in diode emulation a code lowered by decay step keeps emulation, load sets decay
// - overcurrent fault after averaged current above threshold 120us continuously
// - way-overcurrent immediately cuts all drives and power-good
// - phase sense mismatch over 20mV for 1ms latches imbalance fault
// - overvoltage flag above code plus 175mV, masked during transitions
// - soft-start uses fixed 2.33V overvoltage threshold
// - any fault: power-good low, high and low side drives off
// - faults clear only by enable low or power-on reset, then soft-start
// - throttle low below 0.91V, released only above 0.95V
// - alert on 0.93V fall and 0.97V rise, cleared by status read
`timescale 1ns/10ps
module vrmfs_supervisor #(
  parameter int OC_CYC  = vrmfs_pkg::OC_WINDOW_CYC,
  parameter int IMB_CYC = vrmfs_pkg::IMB_WINDOW_CYC
) (
  // clock and reset
  input  wire logic                         mclk_in,
  input  wire logic                         rst_in,
  // serial control link
  input  wire logic                         link_clk_in,
  input  wire logic                         link_cmd_valid_in,
  input  wire vrmfs_pkg::vrmfs_link_cmd_type link_cmd_in,
  // straps and pins
  input  wire logic                         phase3_drive_in,
  output logic                              phase3_drive_out,
  output logic                              phase3_drive_oe_n_out,
  input  wire logic                         phase2_current_sense_in,
  input  wire logic                         config_strap_two_in,
  input  wire logic                         ps_pin_select_in,
  input  wire logic                         power_state_pin_in,
  input  wire logic                         regulator_enable_in,
  input  wire logic                         supply_por_n_in,
  // comparators
  input  wire vrmfs_pkg::vrmfs_cmp_type     cmp_in,
  // drives and mode
  output logic [2:0]                        high_side_en_out,
  output logic [2:0]                        low_side_en_out,
  output vrmfs_pkg::vrmfs_spacing_type      phase_spacing_out,
  output logic                              balance_en_out,
  output logic                              diode_emulation_mode_out,
  output logic                              dcm_out,
  output logic [vrmfs_pkg::VCODE_W-1:0]     vref_code_out,
  output vrmfs_pkg::vrmfs_pstate_type       power_state_out,
  // status
  output logic                              power_good_out,
  output logic                              overvoltage_flag_out,
  output logic                              thermal_throttle_n_out,
  output logic                              bus_alert_n_out,
  output logic                              soft_start_out,
  output vrmfs_pkg::vrmfs_fault_type        fault_out
);

  // ********************
  // link domain
  // ********************
  logic                          lrst_s1_q;
  logic                          lrst_q;
  logic                          ltog_q;
  vrmfs_pkg::vrmfs_link_cmd_type lcmd_q;

  always_ff @(posedge link_clk_in)
  begin
    lrst_s1_q <= rst_in;
    lrst_q    <= lrst_s1_q;
  end

  // command word stays stable until the next toggle
  always_ff @(posedge link_clk_in)
  begin
    if (lrst_q)
    begin
      ltog_q <= 1'b0;
      lcmd_q <= '0;
    end
    else if (link_cmd_valid_in)
    begin
      ltog_q <= ~ltog_q;
      lcmd_q <= link_cmd_in;
    end
  end

  // ********************
  // synchronizers
  // ********************
  localparam int SW = $bits(vrmfs_pkg::vrmfs_cmp_type) + 8;
  logic [SW-1:0] sy1_q;
  logic [SW-1:0] sy2_q;
  logic          tog_old_q;

  always_ff @(posedge mclk_in)
  begin
    sy1_q <= {cmp_in, ltog_q, phase3_drive_in, phase2_current_sense_in,
              config_strap_two_in, ps_pin_select_in, power_state_pin_in,
              regulator_enable_in, supply_por_n_in};
    sy2_q <= sy1_q;
  end

  vrmfs_pkg::vrmfs_cmp_type cmp;
  logic cmd_tog;
  logic p3_s;
  logic p2_s;
  logic config_strap_two_s;
  logic pssel_s;
  logic pspin_s;
  logic en_s;
  logic por_n_s;
  assign {cmp, cmd_tog, p3_s, p2_s, config_strap_two_s, pssel_s, pspin_s, en_s, por_n_s} = sy2_q;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      tog_old_q <= 1'b0;
    else
      tog_old_q <= cmd_tog;
  end

  logic          cmd_evt;
  vrmfs_pkg::vrmfs_cmd_type cmd_code;
  logic [vrmfs_pkg::VCODE_W-1:0] cmd_data;
  assign cmd_evt  = cmd_tog ^ tog_old_q;
  assign cmd_code = lcmd_q.code;
  assign cmd_data = lcmd_q.data;

  // ********************
  // phase configuration
  // ********************
  logic [1:0]              cfg_cnt_q;
  logic                    cfg_ok_q;
  vrmfs_pkg::vrmfs_cfg_type cfg_q;
  logic                    config_strap_two_q;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      cfg_cnt_q <= 2'h0;
      cfg_ok_q  <= 1'b0;
      cfg_q     <= vrmfs_pkg::CFG_THREE;
      config_strap_two_q   <= 1'b0;
    end
    else if (!cfg_ok_q)
    begin
      cfg_cnt_q <= cfg_cnt_q + 2'h1;
      if (cfg_cnt_q == 2'(vrmfs_pkg::CFG_WAIT))
      begin
        cfg_ok_q <= 1'b1;
        config_strap_two_q  <= config_strap_two_s;
        if (p3_s && p2_s)
          cfg_q <= vrmfs_pkg::CFG_ONE;
        else if (p3_s)
          cfg_q <= vrmfs_pkg::CFG_TWO;
        else
          cfg_q <= vrmfs_pkg::CFG_THREE;
      end
    end
  end

  // ********************
  // power state source
  // ********************
  vrmfs_pkg::vrmfs_pstate_type ps_cmd_q;
  vrmfs_pkg::vrmfs_pstate_type ps;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      ps_cmd_q <= vrmfs_pkg::FULL_POWER_STATE;
    else if (cmd_evt && cmd_code == vrmfs_pkg::CMD_SET_PSTATE)
      ps_cmd_q <= vrmfs_pkg::vrmfs_pstate_type'(cmd_data[1:0]);
  end

  // pin high: full, low: reduced
  assign ps = pssel_s ? (pspin_s ? vrmfs_pkg::FULL_POWER_STATE
                                 : vrmfs_pkg::REDUCED_POWER_STATE)
                      : ps_cmd_q;

  // ********************
  // regulator sequence
  // ********************
  typedef enum logic [1:0] {
    RS_OFF   = 2'b00,
    RS_SOFT  = 2'b01,
    RS_RUN   = 2'b10,
    RS_FAULT = 2'b11
  } vrmfs_rstate_type;
  typedef enum logic [1:0] {
    SL_IDLE  = 2'b00,
    SL_FAST  = 2'b01,
    SL_SLOW  = 2'b10,
    SL_DECAY = 2'b11
  } vrmfs_slew_type;

  vrmfs_rstate_type              rs_q;
  vrmfs_slew_type                sl_q;
  logic [vrmfs_pkg::VCODE_W-1:0] ref_q;
  logic [vrmfs_pkg::VCODE_W-1:0] tgt_q;
  logic [vrmfs_pkg::STEP_CNT_W-1:0] step_q;
  vrmfs_pkg::vrmfs_fault_type    flt_q;
  logic                          any_flt;
  logic                          go;
  logic                          done_evt;
  logic                          up;
  logic                          dn;
  logic [vrmfs_pkg::STEP_CNT_W-1:0] step_lim;

  assign any_flt = |flt_q;
  assign go      = en_s && por_n_s && cfg_ok_q;
  assign up      = tgt_q > ref_q;
  assign dn      = tgt_q < ref_q;

  always_comb
  begin
    if (sl_q == SL_FAST && rs_q == RS_RUN)
      step_lim = vrmfs_pkg::STEP_CNT_W'(vrmfs_pkg::FAST_STEP_CYC - 1);
    else
      step_lim = vrmfs_pkg::STEP_CNT_W'(vrmfs_pkg::SLOW_STEP_CYC - 1);
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      rs_q <= RS_OFF;
    else if (!go)
      rs_q <= RS_OFF;
    else
    begin
      unique case (rs_q)
        RS_OFF:   rs_q <= RS_SOFT;
        RS_SOFT:  rs_q <= any_flt ? RS_FAULT : (ref_q == tgt_q ? RS_RUN : RS_SOFT);
        RS_RUN:   rs_q <= any_flt ? RS_FAULT : RS_RUN;
        RS_FAULT: rs_q <= RS_FAULT;
      endcase
    end
  end

  // target and slew kind
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || rs_q == RS_OFF)
    begin
      tgt_q <= vrmfs_pkg::BOOT_CODE;
      sl_q  <= SL_IDLE;
    end
    else if (cmd_evt && (cmd_code == vrmfs_pkg::CMD_STEP_FAST
             || cmd_code == vrmfs_pkg::CMD_STEP_SLOW
             || cmd_code == vrmfs_pkg::CMD_STEP_DECAY))
    begin
      tgt_q <= cmd_data;
      sl_q  <= vrmfs_slew_type'(cmd_code[1:0]);
    end
    else if (ref_q == tgt_q && rs_q == RS_RUN)
      sl_q  <= SL_IDLE;
  end

  // reference stepping, soft-start included
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || rs_q == RS_OFF)
    begin
      ref_q  <= vrmfs_pkg::VCODE_ZERO;
      step_q <= '0;
    end
    else if (rs_q == RS_FAULT || ref_q == tgt_q)
      step_q <= '0;
    else if (step_q < step_lim)
      step_q <= step_q + 1'b1;
    else if (up)
    begin
      ref_q  <= ref_q + 1'b1;
      step_q <= '0;
    end
    else if (dn && (sl_q != SL_DECAY || cmp.vout_below_ref))
    begin
      // decay waits for the load to pull the output, never faster than slow rate
      ref_q  <= ref_q - 1'b1;
      step_q <= '0;
    end
  end

  assign done_evt = rs_q == RS_RUN && ref_q == tgt_q
                    && (sl_q == SL_FAST || sl_q == SL_SLOW);

  // ********************
  // operating mode
  // ********************
  logic [2:0] mask;
  logic       base_de;
  logic       ccm_force;
  logic       de;
  logic [1:0] zc_q;
  logic       dcm_q;
  logic       tick_q;

  always_comb
  begin
    mask = vrmfs_pkg::MASK_ONE;
    unique case (ps)
      vrmfs_pkg::FULL_POWER_STATE:
        mask = cfg_q == vrmfs_pkg::CFG_THREE ? vrmfs_pkg::MASK_THREE
             : cfg_q == vrmfs_pkg::CFG_TWO   ? vrmfs_pkg::MASK_TWO
             : vrmfs_pkg::MASK_ONE;
      vrmfs_pkg::REDUCED_POWER_STATE:
        mask = (cfg_q == vrmfs_pkg::CFG_THREE && config_strap_two_q) ? vrmfs_pkg::MASK_TWO
             : vrmfs_pkg::MASK_ONE;
      vrmfs_pkg::LIGHT_POWER_STATE,
      vrmfs_pkg::LOWEST_POWER_STATE:
        mask = vrmfs_pkg::MASK_ONE;
    endcase
  end

  assign base_de   = ps == vrmfs_pkg::LIGHT_POWER_STATE
                     || ps == vrmfs_pkg::LOWEST_POWER_STATE || sl_q == SL_DECAY;
  assign ccm_force = sl_q == SL_FAST || sl_q == SL_SLOW || up;
  assign de        = base_de && !ccm_force;

  // a tick counts once however long it stays high
  always_ff @(posedge mclk_in)
  begin
    tick_q <= cmp.cycle_tick;
  end

  // zero-crossing run, restarted by a tick without one
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !de)
    begin
      zc_q  <= 2'h0;
      dcm_q <= 1'b0;
    end
    else if (cmp.cycle_tick && !tick_q)
    begin
      if (!cmp.zero_cross)
      begin
        zc_q  <= 2'h0;
        dcm_q <= 1'b0;
      end
      else if (zc_q == 2'(vrmfs_pkg::ZC_CYCLES_FOR_DCM - 1))
        dcm_q <= 1'b1;
      else
        zc_q  <= zc_q + 2'h1;
    end
  end

  // ********************
  // fault timers and latches
  // ********************
  logic [vrmfs_pkg::WIN_CNT_W-1:0] oc_cnt_q;
  logic [vrmfs_pkg::WIN_CNT_W-1:0] imb_cnt_q;
  logic                            live;
  logic                            ov_trip;

  assign live    = rs_q == RS_SOFT || rs_q == RS_RUN;
  assign ov_trip = rs_q == RS_SOFT ? cmp.ov_fixed
                 : (cmp.ov_code && sl_q == SL_IDLE && ref_q == tgt_q);

  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !live || !cmp.oc_above)
      oc_cnt_q <= '0;
    else if (oc_cnt_q != vrmfs_pkg::WIN_CNT_W'(OC_CYC))
      oc_cnt_q <= oc_cnt_q + 1'b1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !live || !cmp.imbalance || cfg_q == vrmfs_pkg::CFG_ONE)
      imb_cnt_q <= '0;
    else if (imb_cnt_q != vrmfs_pkg::WIN_CNT_W'(IMB_CYC))
      imb_cnt_q <= imb_cnt_q + 1'b1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in || rs_q == RS_OFF)
      flt_q <= vrmfs_pkg::FAULT_NONE;
    else if (live)
    begin
      if (oc_cnt_q == vrmfs_pkg::WIN_CNT_W'(OC_CYC))
        flt_q.overcurrent <= 1'b1;
      if (cmp.way_oc)
        flt_q.way_overcurrent <= 1'b1;
      if (imb_cnt_q == vrmfs_pkg::WIN_CNT_W'(IMB_CYC))
        flt_q.imbalance <= 1'b1;
      if (ov_trip)
        flt_q.overvoltage <= 1'b1;
    end
  end

  // ********************
  // thermal and alert
  // ********************
  logic throttle_q;
  logic tzone_q;
  logic alert_q;
  logic tzone_evt;
  logic st_read;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      throttle_q <= 1'b0;
    else if (cmp.ntc_below_091)
      throttle_q <= 1'b1;
    else if (cmp.ntc_above_095)
      throttle_q <= 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      tzone_q <= 1'b0;
    else if (cmp.ntc_below_093)
      tzone_q <= 1'b1;
    else if (cmp.ntc_above_097)
      tzone_q <= 1'b0;
  end

  assign tzone_evt = (cmp.ntc_below_093 && !tzone_q)
                     || (cmp.ntc_above_097 && tzone_q);
  assign st_read   = cmd_evt && cmd_code == vrmfs_pkg::CMD_READ_STATUS;

  // a new event beats a status read in the same cycle
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      alert_q <= 1'b0;
    else if (done_evt || tzone_evt)
      alert_q <= 1'b1;
    else if (st_read)
      alert_q <= 1'b0;
  end

  // ********************
  // drive and power-good registers, output assignments
  // ********************
  logic       drive_ok;
  logic [2:0] hs_q;
  logic [2:0] ls_q;
  logic       pg_q;
  logic       p3_q;

  assign drive_ok = live && !any_flt && !cmp.way_oc;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      hs_q <= 3'h0;
      ls_q <= 3'h0;
      pg_q <= 1'b0;
      p3_q <= 1'b0;
    end
    else
    begin
      hs_q <= drive_ok ? mask : 3'h0;
      ls_q <= (drive_ok && !dcm_q) ? mask : 3'h0;
      pg_q <= rs_q == RS_RUN && !any_flt && !cmp.way_oc;
      p3_q <= drive_ok && mask[2];
    end
  end

  assign high_side_en_out         = hs_q;
  assign low_side_en_out          = ls_q;
  assign power_good_out           = pg_q;
  assign phase3_drive_out         = p3_q;
  assign phase3_drive_oe_n_out    = !(cfg_ok_q && cfg_q == vrmfs_pkg::CFG_THREE);
  assign phase_spacing_out        = cfg_q == vrmfs_pkg::CFG_TWO ? vrmfs_pkg::SPACING_180
                                  : cfg_q == vrmfs_pkg::CFG_ONE ? vrmfs_pkg::SPACING_NONE
                                  : vrmfs_pkg::SPACING_120;
  assign balance_en_out           = cfg_q != vrmfs_pkg::CFG_ONE;
  assign diode_emulation_mode_out = de;
  assign dcm_out                  = dcm_q;
  assign vref_code_out            = ref_q;
  assign power_state_out          = ps;
  assign overvoltage_flag_out     = flt_q.overvoltage;
  assign thermal_throttle_n_out   = !throttle_q;
  assign bus_alert_n_out          = !alert_q;
  assign soft_start_out           = rs_q == RS_SOFT;
  assign fault_out                = flt_q;

endmodule : vrmfs_supervisor

// *** tb/vrmfs_host_model.sv ***
// host model driving the serial control link
`timescale 1ns/10ps
module vrmfs_host_model (
  // link toward the supervisor
  output logic                          link_clk_out,
  output logic                          link_valid_out,
  output vrmfs_pkg::vrmfs_link_cmd_type link_cmd_out
);
  initial
  begin
    link_clk_out = 1'b0;
    link_valid_out = 1'b0;
    link_cmd_out = 11'h000;
  end
  // clock runs only in frames; idle word flips
  task automatic pulse(input int n);
    repeat (n)
    begin
      #16 link_clk_out = 1'b1;
      link_cmd_out <= ~link_cmd_out;
      #16 link_clk_out = 1'b0;
    end
  endtask : pulse
  task automatic send(input vrmfs_pkg::vrmfs_cmd_type c, input logic [7:0] d);
    #7.3;
    link_cmd_out = {c, d};
    link_valid_out = 1'b1;
    #16 link_clk_out = 1'b1;
    link_valid_out <= 1'b0;
    link_cmd_out <= ~{c, d};
    #16 link_clk_out = 1'b0;
    pulse(3);
  endtask : send
endmodule : vrmfs_host_model

// *** tb/vrmfs_properties.sv ***
// port assertions of the supervisor
`timescale 1ns/10ps
module vrmfs_properties #(
  parameter int OC_CYC = 20
) (
  // clock, reset, enables
  input wire logic                         mclk_in,
  input wire logic                         rst_in,
  input wire logic                         regulator_enable_in,
  input wire logic                         supply_por_n_in,
  input wire vrmfs_pkg::vrmfs_cmp_type     cmp_in,
  // watched outputs
  input wire logic [2:0]                   high_side_en_out,
  input wire logic [2:0]                   low_side_en_out,
  input wire vrmfs_pkg::vrmfs_spacing_type phase_spacing_out,
  input wire logic                         balance_en_out,
  input wire logic                         power_good_out,
  input wire logic                         thermal_throttle_n_out,
  input wire vrmfs_pkg::vrmfs_fault_type   fault_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // cycles the raw overcurrent level has been high
  logic [19:0] oc_q;
  always_ff @(posedge mclk_in) oc_q <= cmp_in.oc_above ? oc_q + 20'h1 : 20'h0;
  sequence en_held;
    (regulator_enable_in && supply_por_n_in) [*4];
  endsequence
  sequence hot_held;
    (!rst_in && cmp_in.ntc_below_091) [*5];
  endsequence
  a_oc_window: assert property ($rose(fault_out.overcurrent) |-> oc_q >= OC_CYC)
    else $error("early overcurrent");
  a_fault_off: assert property ((fault_out != 4'h0) |=>
    (high_side_en_out == 3'h0 && low_side_en_out == 3'h0 && !power_good_out))
    else $error("drive on in fault");
  a_fault_latch: assert property (en_held ##0 (fault_out != 4'h0) |=> fault_out != 4'h0)
    else $error("fault lost");
  a_wayoc_cut: assert property ($rose(fault_out.way_overcurrent) |->
    !power_good_out && high_side_en_out == 3'h0)
    else $error("slow way cut");
  a_power_good_out_reset: assert property ($fell(rst_in) |-> (!power_good_out) [*3])
    else $error("early power good");
  a_one_phase: assert property (phase_spacing_out == vrmfs_pkg::SPACING_NONE |->
    !balance_en_out && high_side_en_out[2:1] == 2'h0)
    else $error("extra phase on");
  a_two_phase: assert property (phase_spacing_out == vrmfs_pkg::SPACING_180 |->
    !high_side_en_out[2] && !low_side_en_out[2])
    else $error("phase three on");
  a_throttle_hold: assert property ((!thermal_throttle_n_out && !cmp_in.ntc_above_095) [*4]
    |=> !thermal_throttle_n_out)
    else $error("early release");
  a_throttle_set: assert property (hot_held |=> !thermal_throttle_n_out)
    else $error("no throttle");
endmodule : vrmfs_properties

// *** tb/vrmfs_supervisor_tb.sv ***
// self-checking bench of the supervisor
`timescale 1ns/10ps
`define CHK(n, e, s) \
  begin n_compared++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module vrmfs_supervisor_tb;
  localparam int OC_P = 20;
  localparam int IMB_P = 40;
  logic mclk_in = 1'b0, rst_in = 1'b1, p3_strap = 1'b0, link_clk_in, link_cmd_valid_in;
  logic phase2_current_sense_in = 1'b0, config_strap_two_in = 1'b0, ps_pin_select_in = 1'b0;
  logic power_state_pin_in = 1'b0, regulator_enable_in = 1'b0, supply_por_n_in = 1'b1;
  logic [2:0] high_side_en_out, low_side_en_out;
  logic [7:0] vref_code_out;
  logic balance_en_out, diode_emulation_mode_out, dcm_out, power_good_out, soft_start_out;
  logic overvoltage_flag_out, thermal_throttle_n_out, bus_alert_n_out;
  logic phase3_drive_out, phase3_drive_oe_n_out;
  wire logic phase3_drive_in = phase3_drive_oe_n_out ? p3_strap : phase3_drive_out;
  vrmfs_pkg::vrmfs_link_cmd_type link_cmd_in;
  vrmfs_pkg::vrmfs_cmp_type cmp_in = 12'h028;
  vrmfs_pkg::vrmfs_spacing_type phase_spacing_out;
  vrmfs_pkg::vrmfs_pstate_type power_state_out;
  vrmfs_pkg::vrmfs_fault_type fault_out;
  int seed = 32'h8A71, miscompares = 0, n_compared = 0, cnt, ph, lim;
  // {b091, a095, b093, a097, throttle_n, alert_n}
  logic [5:0] tv [5] = '{6'h0A, 6'h29, 6'h21, 6'h13, 6'h16};
  initial forever #2 mclk_in = ~mclk_in;
  vrmfs_supervisor #(.OC_CYC(OC_P), .IMB_CYC(IMB_P)) i_dut (.mclk_in, .rst_in, .link_clk_in,
    .link_cmd_valid_in, .link_cmd_in, .phase3_drive_in, .phase3_drive_out,
    .phase3_drive_oe_n_out, .phase2_current_sense_in, .config_strap_two_in, .ps_pin_select_in,
    .power_state_pin_in, .regulator_enable_in, .supply_por_n_in, .cmp_in, .high_side_en_out,
    .low_side_en_out, .phase_spacing_out, .balance_en_out, .diode_emulation_mode_out, .dcm_out,
    .vref_code_out, .power_state_out, .power_good_out, .overvoltage_flag_out,
    .thermal_throttle_n_out, .bus_alert_n_out, .soft_start_out, .fault_out);
  vrmfs_host_model i_host (.link_clk_out(link_clk_in), .link_valid_out(link_cmd_valid_in),
    .link_cmd_out(link_cmd_in));
  task automatic final_report();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic lim_check(input int c, input int l);
    if (c >= l)
    begin
      miscompares++;
      final_report();
    end
  endtask : lim_check
  task automatic wait_pg();
    for (cnt = 0; cnt < 50 && power_good_out !== 1'b1; cnt++) @(posedge mclk_in);
    lim_check(cnt, 50);
  endtask : wait_pg
  task automatic boot(input int c);
    rst_in <= 1'b1;
    regulator_enable_in <= 1'b0;
    p3_strap <= c > 0;
    phase2_current_sense_in <= c > 1;
    config_strap_two_in <= 1'($random(seed));
    repeat (8) @(posedge mclk_in);
    i_host.pulse(3);
    @(posedge mclk_in);
    rst_in <= 1'b0;
    i_host.pulse(3);
    repeat (6) @(posedge mclk_in);
    `CHK("pg_rst", 1'b0, power_good_out)
    regulator_enable_in <= 1'b1;
    wait_pg();
  endtask : boot
  task automatic read_status();
    i_host.send(vrmfs_pkg::CMD_READ_STATUS, 8'h00);
    repeat (4) @(posedge mclk_in);
    `CHK("alert_clr", 1'b1, bus_alert_n_out)
  endtask : read_status
  initial
  begin
    for (int c = 2; c >= 0; c--)
    begin
      boot(c);
      `CHK("spacing", c, phase_spacing_out)
      `CHK("balance", c < 2, balance_en_out)
      `CHK("oe_n", c > 0, phase3_drive_oe_n_out)
      for (int ps = 0; ps < 4; ps++)
      begin
        ps_pin_select_in <= ps < 2 && $random(seed) % 2 == 0;
        power_state_pin_in <= ps == 0;
        i_host.send(vrmfs_pkg::CMD_SET_PSTATE, 8'(ps));
        repeat (12) @(posedge mclk_in);
        ph = ps > 1 ? 1 : ps == 0 ? 3 - c : (c == 0 && config_strap_two_in) ? 2 : 1;
        `CHK("pstate", ps, power_state_out)
        `CHK("de", ps > 1, diode_emulation_mode_out)
        `CHK("hs_en", (1 << ph) - 1, high_side_en_out)
      end
    end
    ps_pin_select_in <= 1'b0;
    i_host.send(vrmfs_pkg::CMD_SET_PSTATE, 8'h00);
    for (int k = 1; k < 3; k++)
    begin
      i_host.send(vrmfs_pkg::vrmfs_cmd_type'(k), 8'(2 * k));
      lim = 2 * (k == 1 ? vrmfs_pkg::FAST_STEP_CYC : vrmfs_pkg::SLOW_STEP_CYC) + 12;
      for (cnt = 0; cnt < lim && vref_code_out !== 8'(2 * k); cnt++) @(posedge mclk_in);
      lim_check(cnt, lim);
      repeat (3) @(posedge mclk_in);
      `CHK("alert", 1'b0, bus_alert_n_out)
      read_status();
    end
    cmp_in.vout_below_ref <= 1'b1;
    i_host.send(vrmfs_pkg::CMD_STEP_DECAY, 8'h00);
    `CHK("decay_de", 1'b1, diode_emulation_mode_out)
    for (cnt = 0; cnt < 2100 && vref_code_out !== 8'h00; cnt++) @(posedge mclk_in);
    lim_check(cnt, 2100);
    `CHK("decay_clamp", 1'b1, cnt > 2 * vrmfs_pkg::SLOW_STEP_CYC)
    `CHK("decay_alert", 1'b1, bus_alert_n_out)
    cmp_in.vout_below_ref <= 1'b0;
    i_host.send(vrmfs_pkg::CMD_SET_PSTATE, 8'h02);
    cmp_in.zero_cross <= 1'b1;
    for (int t = 0; t < 5; t++)
    begin
      repeat (4) @(posedge mclk_in);
      `CHK("dcm", t > 3, dcm_out)
      cmp_in.cycle_tick <= t < 4;
      repeat (2) @(posedge mclk_in);
      cmp_in.cycle_tick <= 1'b0;
    end
    cmp_in.zero_cross <= 1'b0;
    for (int f = 0; f < 4; f++)
    begin
      lim = f == 3 ? OC_P : f == 1 ? IMB_P : 0;
      if (lim > 0)
      begin
        cmp_in[8 + f] <= 1'b1;
        repeat (lim - 5) @(posedge mclk_in);
        cmp_in[8 + f] <= 1'b0;
        repeat (4) @(posedge mclk_in);
      end
      cmp_in[8 + f] <= 1'b1;
      for (cnt = 0; cnt < 90 && fault_out === 4'h0; cnt++) @(posedge mclk_in);
      lim_check(cnt, 90);
      `CHK("fault", 4'h1 << f, fault_out)
      `CHK("window", 1'b1, cnt >= lim && cnt <= lim + 6)
      repeat (2) @(posedge mclk_in);
      `CHK("off", 7'h00, {power_good_out, high_side_en_out, low_side_en_out})
      `CHK("ovflag", f == 0, overvoltage_flag_out)
      cmp_in[8 + f] <= 1'b0;
      repeat (8) @(posedge mclk_in);
      `CHK("held", 4'h1 << f, fault_out)
      regulator_enable_in <= 1'b0;
      repeat (6) @(posedge mclk_in);
      `CHK("cleared", 4'h0, fault_out)
      regulator_enable_in <= 1'b1;
      wait_pg();
    end
    foreach (tv[i])
    begin
      cmp_in[6:3] <= tv[i][5:2];
      repeat (6) @(posedge mclk_in);
      `CHK("therm", tv[i][1:0], {thermal_throttle_n_out, bus_alert_n_out})
      if (!tv[i][0])
        read_status();
    end
    final_report();
  end
endmodule : vrmfs_supervisor_tb
bind vrmfs_supervisor vrmfs_properties #(.OC_CYC(OC_CYC)) i_props (.mclk_in, .rst_in,
  .regulator_enable_in, .supply_por_n_in, .cmp_in, .high_side_en_out, .low_side_en_out,
  .phase_spacing_out, .balance_en_out, .power_good_out, .thermal_throttle_n_out, .fault_out);
